/* hw/fppio_top.sv */
// Four-port parallel I/O with AHB-Lite register access.
// Assumes an external pad ring that resolves each pin from out, oe and in.
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Port A data 0x0, direction 0x4
// - Reset clears directions, keeps data latches
// - Port B lines 5..7, offsets 0x1/0x5
// - Port C eight lines, offsets 0x2/0x6
// - Port D offsets 0x3/0x7, direction bit 5
// - Direction 1 drives latch, 0 floats
// - Input-mode writes stored, appear later
// - Port D bit 7 reads input line
// - Serial port enable hands port B away
// - Port B registers stay accessible meanwhile
// - Port C 3..7 shared with converter
// - Port D independent of timer, feeds capture
// - Build option swaps line 5 for clock
// - Port A optionally feeds interrupt requests
module fppio_top
    import fppio_pkg::*;
#(
    parameter bit CLOCK_OUT_OPTION = 1'b0
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic [31:0] hrdata,
    input  wire logic [7:0]  port_a_lines_in,
    output var  logic [7:0]  port_a_lines_out,
    output var  logic [7:0]  port_a_lines_oe,
    input  wire logic [7:0]  port_b_lines_in,
    output var  logic [7:0]  port_b_lines_out,
    output var  logic [7:0]  port_b_lines_oe,
    input  wire logic [7:0]  port_c_lines_in,
    output var  logic [7:0]  port_c_lines_out,
    output var  logic [7:0]  port_c_lines_oe,
    input  wire logic        port_d_line5_or_clock_out_in,
    output var  logic        port_d_line5_or_clock_out_out,
    output var  logic        port_d_line5_or_clock_out_oe,
    input  wire logic        port_d_input_line,
    input  wire logic        clock_output,
    output var  logic        serial_port_enable_bit,
    output var  logic        converter_power_on_bit,
    output var  logic        timer_capture_input,
    output var  logic [7:0]  port_a_irq_lines,
    output var  logic        port_a_irq_enable
);

    // ********************************
    // Storage
    // ********************************
    fppio_ports_t data_r;
    fppio_ports_t dir_r;
    logic [7:0]   share_r;
    logic         wr_pend_r;
    logic         wr_share_r;
    logic [2:0]   wr_idx_r;
    logic [31:0]  hrdata_r;
    logic         access;
    logic         in_ports;
    logic         in_share;
    logic [2:0]   idx;
    logic [7:0]   wbyte;
    logic [7:0]   rd_nxt;
    fppio_ports_t pins;
    wire fppio_ports_t rd_view;

    assign access   = hsel && hready && (htrans == FPPIO_HTRANS_NONSEQ);
    assign in_ports = (haddr[31:5] == 27'h0);
    assign in_share = (haddr[31:0] == {26'h0, FPPIO_ADDR_SHARE});
    assign idx      = haddr[FPPIO_WORD_SHIFT+2:FPPIO_WORD_SHIFT];
    assign wbyte    = hwdata[7:0];

    // Zero-wait slave; OKAY always
    // No stall, so a read right behind a write sees the old value
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    assign pins.a = port_a_lines_in;
    assign pins.b = port_b_lines_in & FPPIO_B_MASK;
    assign pins.c = port_c_lines_in;
    assign pins.d = {port_d_input_line, 1'b0, port_d_line5_or_clock_out_in, 5'h00};

    // ********************************
    // Address phase capture
    // ********************************
    // Writes land one cycle later, in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r  <= 1'b0;
            wr_share_r <= 1'b0;
        end
        else
        begin
            wr_pend_r  <= access && hwrite && in_ports;
            wr_share_r <= access && hwrite && in_share;
        end
    end

    // Index moves only on a taken write
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_idx_r <= 3'h0;
        end
        else if (access && hwrite)
        begin
            wr_idx_r <= idx;
        end
    end

    // ********************************
    // Data latches, no reset
    // ********************************
    // Latches keep contents across reset, so no reset branch
    always_ff @(posedge hclk)
    begin
        if (wr_pend_r && (wr_idx_r == FPPIO_IDX_A_DATA))
        begin
            data_r.a <= wbyte;
        end
    end

    // Written while the serial port runs, the value waits in the latch, off the pads
    always_ff @(posedge hclk)
    begin
        if (wr_pend_r && (wr_idx_r == FPPIO_IDX_B_DATA))
        begin
            data_r.b <= wbyte & FPPIO_B_MASK;
        end
    end

    always_ff @(posedge hclk)
    begin
        if (wr_pend_r && (wr_idx_r == FPPIO_IDX_C_DATA))
        begin
            data_r.c <= wbyte;
        end
    end

    // Bit 7 is never stored; reads take it from the pad
    always_ff @(posedge hclk)
    begin
        if (wr_pend_r && (wr_idx_r == FPPIO_IDX_D_DATA))
        begin
            data_r.d <= wbyte & FPPIO_D_DATA_MASK;
        end
    end

    // ********************************
    // Direction registers
    // ********************************
    // Reset turns every pad but the clock-option port D line 5 into an input before software runs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dir_r.a <= FPPIO_DIR_RESET;
        end
        else if (wr_pend_r && (wr_idx_r == FPPIO_IDX_A_DIR))
        begin
            dir_r.a <= wbyte;
        end
    end

    // Only bits 7 to 5 exist; the rest stay zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dir_r.b <= FPPIO_DIR_RESET;
        end
        else if (wr_pend_r && (wr_idx_r == FPPIO_IDX_B_DIR))
        begin
            dir_r.b <= wbyte & FPPIO_B_MASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dir_r.c <= FPPIO_DIR_RESET;
        end
        else if (wr_pend_r && (wr_idx_r == FPPIO_IDX_C_DIR))
        begin
            dir_r.c <= wbyte;
        end
    end

    // Only bit 5 has a direction; bit 7 is input only
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dir_r.d <= FPPIO_DIR_RESET;
        end
        else if (wr_pend_r && (wr_idx_r == FPPIO_IDX_D_DIR))
        begin
            dir_r.d <= wbyte & FPPIO_D_DIR_MASK;
        end
    end

    // ********************************
    // Sharing control register
    // ********************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            // Stands in for the serial, converter and interrupt controls
            share_r <= FPPIO_SHARE_RESET;
        end
        else if (wr_share_r)
        begin
            share_r <= wbyte & FPPIO_SHARE_MASK;
        end
    end

    assign serial_port_enable_bit = share_r[FPPIO_SHARE_SPE];
    assign converter_power_on_bit = share_r[FPPIO_SHARE_CONVERTER_POWER_ON_BIT];
    assign port_a_irq_enable      = share_r[FPPIO_SHARE_IRQEN];

    // ********************************
    // Read path
    // ********************************
    // Outputs read the latch, so an overloaded pad reads as written
    for (genvar i = 0; i < 32; i++)
    begin : g_view
        assign rd_view[i] = dir_r[i] ? data_r[i] : pins[i];
    end

    always_comb
    begin
        rd_nxt = 8'h00;
        if (in_share)
        begin
            rd_nxt = share_r;
        end
        else if (in_ports)
        begin
            case (idx)
                FPPIO_IDX_A_DATA: rd_nxt = rd_view.a;
                FPPIO_IDX_B_DATA: rd_nxt = rd_view.b & FPPIO_B_MASK;
                FPPIO_IDX_C_DATA: rd_nxt = rd_view.c;
                FPPIO_IDX_D_DATA:
                begin
                    rd_nxt = rd_view.d & FPPIO_D_DATA_MASK;
                    rd_nxt[FPPIO_D_INPUT] = port_d_input_line;
                end
                FPPIO_IDX_A_DIR: rd_nxt = dir_r.a;
                FPPIO_IDX_B_DIR: rd_nxt = dir_r.b;
                FPPIO_IDX_C_DIR: rd_nxt = dir_r.c;
                FPPIO_IDX_D_DIR: rd_nxt = dir_r.d;
                default:         rd_nxt = 8'h00;
            endcase
        end
    end

    // Pads are sampled in the address phase, not the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata_r <= 32'h0;
        end
        else if (access && !hwrite)
        begin
            hrdata_r <= {24'h0, rd_nxt};
        end
    end

    // ********************************
    // Pin drivers
    // ********************************
    // Latch always feeds the pad; the enable alone decides
    always_comb
    begin
        port_a_lines_out = data_r.a;
        port_a_lines_oe  = dir_r.a;
    end

    // Serial port owns port B pads while enabled
    always_comb
    begin
        port_b_lines_out = data_r.b;
        if (serial_port_enable_bit)
        begin
            port_b_lines_oe = 8'h00;
        end
        else
        begin
            port_b_lines_oe = dir_r.b;
        end
    end

    // Converter only senses; pad stays as programmed
    always_comb
    begin
        port_c_lines_out = data_r.c;
        port_c_lines_oe  = dir_r.c;
    end

    // Option fixed at build time; software cannot undo it
    always_comb
    begin
        if (CLOCK_OUT_OPTION)
        begin
            port_d_line5_or_clock_out_out = clock_output;
            port_d_line5_or_clock_out_oe  = 1'b1;
        end
        else
        begin
            port_d_line5_or_clock_out_out = data_r.d[FPPIO_D_LINE5];
            port_d_line5_or_clock_out_oe  = dir_r.d[FPPIO_D_LINE5];
        end
    end

    // ********************************
    // Shared functions
    // ********************************
    assign timer_capture_input = port_d_input_line;
    assign port_a_irq_lines    = port_a_irq_enable ? port_a_lines_in : 8'h00;

endmodule : fppio_top

`default_nettype wire

/* common/fppio_pkg.sv */
// Package for the four-port parallel I/O block: offsets, masks, carriers.
// Assumes an AHB-Lite slave with 32-bit data and word-aligned registers.
package fppio_pkg;

    // ********************************
    // Register indexes and addresses
    // ********************************
    localparam logic [2:0] FPPIO_IDX_A_DATA  = 3'h0;
    localparam logic [2:0] FPPIO_IDX_B_DATA  = 3'h1;
    localparam logic [2:0] FPPIO_IDX_C_DATA  = 3'h2;
    localparam logic [2:0] FPPIO_IDX_D_DATA  = 3'h3;
    localparam logic [2:0] FPPIO_IDX_A_DIR   = 3'h4;
    localparam logic [2:0] FPPIO_IDX_B_DIR   = 3'h5;
    localparam logic [2:0] FPPIO_IDX_C_DIR   = 3'h6;
    localparam logic [2:0] FPPIO_IDX_D_DIR   = 3'h7;
    localparam logic [2:0] FPPIO_IDX_SHARE   = 3'h0;
    localparam int         FPPIO_WORD_SHIFT  = 2;
    localparam logic [5:0] FPPIO_ADDR_SHARE  = 6'h20;

    // ********************************
    // Field masks and positions
    // ********************************
    localparam logic [7:0] FPPIO_B_MASK      = 8'he0;
    localparam logic [7:0] FPPIO_D_DIR_MASK  = 8'h20;
    localparam logic [7:0] FPPIO_D_DATA_MASK = 8'h20;
    localparam int         FPPIO_D_LINE5     = 5;
    localparam int         FPPIO_D_INPUT     = 7;
    localparam logic [7:0] FPPIO_C_CONV_MASK = 8'hf8;
    localparam int         FPPIO_SHARE_SPE   = 0;
    localparam int         FPPIO_SHARE_CONVERTER_POWER_ON_BIT  = 1;
    localparam int         FPPIO_SHARE_IRQEN = 2;
    localparam logic [7:0] FPPIO_SHARE_MASK  = 8'h07;
    localparam logic [7:0] FPPIO_DIR_RESET   = 8'h00;
    localparam logic [7:0] FPPIO_SHARE_RESET = 8'h00;

    localparam logic [1:0] FPPIO_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] FPPIO_HRESP_OKAY    = 2'h0;

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
        logic [7:0] d;
    } fppio_ports_t;

endpackage : fppio_pkg

/* testbench/fppio_board.sv */
// Board model: resolves each port pin from the block's drive.
// Assumes the package carrier; released lines show the board level.
`timescale 1ns/1ps
`default_nettype none
module fppio_board
    import fppio_pkg::*;
(
    input  wire fppio_ports_t pin_out,
    input  wire fppio_ports_t pin_oe,
    input  wire fppio_ports_t board_lvl,
    output wire fppio_ports_t pin_lvl
);
    // Unconnected enable bits count as released
    for (genvar i = 0; i < 32; i++)
    begin : g_pin
        assign pin_lvl[i] = (pin_oe[i] === 1'b1) ? pin_out[i] : board_lvl[i];
    end
endmodule : fppio_board
`default_nettype wire

/* testbench/fppio_properties.sv */
// Checker of the parallel I/O block, bound to its top module.
// Assumes a zero-wait slave, pins sampled at the address phase.
`timescale 1ns/1ps
`default_nettype none
module fppio_properties
    import fppio_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic [7:0]  port_a_lines_in,
    input wire logic [7:0]  port_a_lines_oe,
    input wire logic [7:0]  port_b_lines_oe,
    input wire logic [7:0]  port_c_lines_oe,
    input wire logic        port_d_input_line,
    input wire logic        serial_port_enable_bit,
    input wire logic        timer_capture_input,
    input wire logic [7:0]  port_a_irq_lines,
    input wire logic        port_a_irq_enable
);
    logic tk;
    assign tk = hsel && hready && htrans == FPPIO_HTRANS_NONSEQ;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_dir_reset: assert property (
        $rose(hresetn) |-> {port_a_lines_oe, port_b_lines_oe, port_c_lines_oe} == 24'h0)
        else $error("direction not cleared by reset");
    a_dir_write: assert property (
        tk && hwrite && haddr == 32'h10 |-> ##2 port_a_lines_oe == $past(hwdata[7:0]))
        else $error("port A direction write lost");
    a_c_dir_hold: assert property (
        !$past(tk && hwrite && haddr == 32'h18, 2) |-> $stable(port_c_lines_oe))
        else $error("port C direction moved unasked");
    a_read_input: assert property (
        tk && !hwrite && haddr == 32'hc
        |=> hrdata[7] == $past(port_d_input_line) && (hrdata[7:0] & 8'h5f) == 8'h0)
        else $error("port D read wrong");
    a_serial_owns: assert property (
        serial_port_enable_bit |-> port_b_lines_oe == 8'h0)
        else $error("port B driven under serial port");
    a_b_unused: assert property (
        (port_b_lines_oe & ~FPPIO_B_MASK) == 8'h0)
        else $error("port B low bits driven");
    a_capture_copy: assert property (
        timer_capture_input == port_d_input_line)
        else $error("capture input differs");
    a_irq_gate: assert property (
        port_a_irq_lines == (port_a_irq_enable ? port_a_lines_in : 8'h0))
        else $error("interrupt lines wrong");
endmodule : fppio_properties
bind fppio_top fppio_properties i_props (.*);
`default_nettype wire

/* testbench/tb_fppio_top.sv */
// Bench of the parallel I/O block: reset values, register rows, then special cases.
// Assumes the board model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_fppio_top
    import fppio_pkg::*;
;
    logic         hclk = 1'b0;
    logic         hresetn = 1'b0;
    logic         hsel = 1'b0;
    logic [31:0]  haddr = 32'h0;
    logic [1:0]   htrans = 2'h0;
    logic         hwrite = 1'b0;
    logic [31:0]  hwdata = 32'h0;
    logic         clock_output = 1'b0;
    logic [31:0]  rd;
    fppio_ports_t ext_s = '0;
    wire fppio_ports_t pin_out, pin_oe, pin_lvl;
    wire logic hreadyout, hresp, serial_port_enable_bit, converter_power_on_bit;
    wire logic timer_capture_input, port_a_irq_enable;
    wire logic [7:0]  port_a_irq_lines;
    wire logic [31:0] hrdata;
    int fails = 0;
    int samples_checked = 0;
    localparam logic [7:0] DM [4] = '{8'hff, 8'he0, 8'hff, 8'h20};
    localparam logic [31:0] ROWS [5] = '{32'h00a5f03c, 32'h015aff00, 32'h023c0fc3,
                                         32'h03ffff00, 32'h0300ff80};
    fppio_top i_dut (.*, .hsize(3'h2), .hready(hreadyout),
        .port_a_lines_in(pin_lvl.a), .port_a_lines_out(pin_out.a), .port_a_lines_oe(pin_oe.a),
        .port_b_lines_in(pin_lvl.b), .port_b_lines_out(pin_out.b), .port_b_lines_oe(pin_oe.b),
        .port_c_lines_in(pin_lvl.c), .port_c_lines_out(pin_out.c), .port_c_lines_oe(pin_oe.c),
        .port_d_line5_or_clock_out_in(pin_lvl.d[5]), .port_d_line5_or_clock_out_out(pin_out.d[5]),
        .port_d_line5_or_clock_out_oe(pin_oe.d[5]), .port_d_input_line(pin_lvl.d[7]));
    fppio_board i_board (.pin_out(pin_out), .pin_oe(pin_oe), .board_lvl(ext_s), .pin_lvl(pin_lvl));
    // Second copy built with the clock output option
    wire logic ck_out, ck_oe;
    fppio_top #(.CLOCK_OUT_OPTION(1'b1)) i_dut_clk (.hclk(hclk), .hresetn(hresetn),
        .hsel(1'b0), .haddr(32'h0), .htrans(2'h0), .hwrite(1'b0), .hsize(3'h2),
        .hwdata(32'h0), .hready(1'b1), .hreadyout(), .hresp(), .hrdata(),
        .port_a_lines_in(8'h00), .port_a_lines_out(), .port_a_lines_oe(),
        .port_b_lines_in(8'h00), .port_b_lines_out(), .port_b_lines_oe(),
        .port_c_lines_in(8'h00), .port_c_lines_out(), .port_c_lines_oe(),
        .port_d_line5_or_clock_out_in(1'b0), .port_d_line5_or_clock_out_out(ck_out),
        .port_d_line5_or_clock_out_oe(ck_oe), .port_d_input_line(1'b0),
        .clock_output(clock_output), .serial_port_enable_bit(), .converter_power_on_bit(),
        .timer_capture_input(), .port_a_irq_lines(), .port_a_irq_enable());
    initial forever #5 hclk = ~hclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Waits for hready in both phases; the slave sets the pace
    task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= FPPIO_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic end_sim;
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    initial
    begin
        #100us;
        fails++;
        end_sim();
    end
    initial
    begin
        int p;
        logic [7:0] dt, dr, ex, dd;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 4; i < 8; i++)
        begin
            bus(1'b0, 32'(i * 4), 8'h0);
            chk(rd, 32'h0);
        end
        $display("reset values done");
        for (int r = 0; r < 5; r++)
        begin
            p = int'(ROWS[r][25:24]);
            {dt, dr, ex} = ROWS[r][23:0];
            ext_s <= {4{ex}};
            bus(1'b1, 32'((p + 4) * 4), 8'h0);
            // Data before direction, so no glitch on the pin
            bus(1'b1, 32'(p * 4), dt);
            @(negedge hclk);
            chk(pin_lvl[31 - 8 * p -: 8], ex);
            bus(1'b1, 32'((p + 4) * 4), dr);
            bus(1'b0, 32'((p + 4) * 4), 8'h0);
            dd = dr & DM[p];
            chk(rd, {24'h0, dd});
            bus(1'b0, 32'(p * 4), 8'h0);
            chk(rd, {24'h0, (dd & dt) | (DM[p] & ~dr & ex) | (p == 3 ? ex & 8'h80 : 8'h0)});
            chk(pin_lvl[31 - 8 * p -: 8], (dd & dt) | (~dd & ex));
        end
        $display("register rows done");
        bus(1'b1, 32'h20, 8'h01);
        @(negedge hclk);
        chk(pin_oe.b, 8'h0);
        bus(1'b1, 32'h14, 8'h20);
        bus(1'b0, 32'h14, 8'h0);
        chk(rd, 32'h20);
        bus(1'b1, 32'h20, 8'h06);
        @(negedge hclk);
        chk({serial_port_enable_bit, converter_power_on_bit, port_a_irq_enable}, 3'h3);
        chk(pin_oe.b, 8'h20);
        chk(pin_lvl.c, 8'h8c);
        chk(port_a_irq_lines, pin_lvl.a);
        chk(timer_capture_input, ext_s.d[7]);
        bus(1'b0, 32'h24, 8'h0);
        chk(rd, 32'h0);
        chk({hreadyout, hresp}, 2'h2);
        clock_output <= 1'b1;
        @(negedge hclk);
        chk({ck_oe, ck_out}, 2'h3);
        @(posedge hclk);
        clock_output <= 1'b0;
        @(negedge hclk);
        chk({ck_oe, ck_out}, 2'h2);
        $display("sharing cases done");
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 32'h10, 8'h0);
        chk(rd, 32'h0);
        bus(1'b1, 32'h10, 8'hff);
        bus(1'b0, 32'h0, 8'h0);
        chk(rd, 32'ha5);
        $display("second reset done");
        end_sim();
    end
endmodule : tb_fppio_top
`default_nettype wire
